// ### logic/vtd_pkg.sv
// Package: register map, field layout, reset values and timing for the trip detector
`default_nettype none
package vtd_pkg;
    // ********************
    // Register offsets
    // ********************
    localparam logic [7:0] CTRL_OFFSET     = 8'h00; // Control register
    localparam logic [7:0] FLAG_OFFSET     = 8'h04; // Event flag register
    localparam logic [7:0] IRQEN_OFFSET    = 8'h08; // Interrupt enable register
    localparam logic [7:0] CORE_OFFSET     = 8'h0C; // Global enable and sleep
    // ********************
    // Field positions
    // ********************
    localparam int LEVEL_LSB   = 0;  // Trip level low bit
    localparam int ENABLE_BIT  = 4;  // Detector enable
    localparam int STABLE_BIT  = 5;  // Reference stable, read only
    localparam int UNUSED_BIT  = 6;  // Unimplemented
    localparam int DIR_BIT     = 7;  // Direction select
    localparam int EVENT_BIT   = 2;  // Event flag and its enable
    localparam int PRIO_BIT    = 2;  // Priority bit number, unused; the enable word keeps priority at PRIO_POS
    localparam int PRIO_POS    = 8;  // Priority position in the enable register
    localparam int GIE_BIT     = 7;  // Global enable in core word
    localparam int SLEEP_BIT   = 0;  // Sleep request in core word
    // ********************
    // Reset values
    // ********************
    localparam logic [7:0] CTRL_RESET  = 8'h05; // Level 0101, everything else off
    localparam logic [3:0] LEVEL_EXT   = 4'hF;  // Code that selects the external pin
    // ********************
    // Timing
    // ********************
    localparam int CLK_HZ        = 50_000_000;
    localparam int SETTLE_NS     = 20_000;     // Reference settle time in ns
    localparam int SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Detector state
    typedef enum logic [2:0]
    {
        ST_OFF    = 3'b001,
        ST_SETTLE = 3'b010,
        ST_ARMED  = 3'b100
    } det_state_t;
endpackage : vtd_pkg
`default_nettype wire

// ### logic/vtd_sync_if.sv
// Interface: synchronised analog status carried between the synchroniser and the core
`timescale 1ns/1ps
`default_nettype none
interface vtd_sync_if;
    logic cmp_hi;    // Synchronised comparator: voltage at or above trip
    logic ref_ready; // Synchronised reference-ready indication
    modport src (output cmp_hi, output ref_ready);
    modport dst (input cmp_hi, input ref_ready);
endinterface : vtd_sync_if
`default_nettype wire

// ### logic/vtd_sync.sv
// Two-stage synchroniser for the comparator output and the reference-ready level
`timescale 1ns/1ps
`default_nettype none
module vtd_sync
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   cmp_async,
    input  wire logic   ref_async,
    vtd_sync_if.src     sync
);
    logic [1:0] meta_ff;   // First stage, read only by the second
    logic [1:0] stable_ff; // Second stage
    // ********************
    // Synchroniser stages
    // ********************
    // two flop crossing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff   <= 2'h0;
            stable_ff <= 2'h0;
        end
        else
        begin
            meta_ff   <= {ref_async, cmp_async};
            stable_ff <= meta_ff;
        end
    end
    assign sync.cmp_hi    = stable_ff[0];
    assign sync.ref_ready = stable_ff[1];
endmodule : vtd_sync
`default_nettype wire

// ### logic/voltage_trip_detector.sv
// Top of the voltage trip detector: APB registers, settling control and event logic
//
// Function
// - Detector runs only while enable set
// - Stable flag clears on enable, read only
// - No event before reference is stable
// - Direction picks rise or fall trip
// - Four bit level picks sixteen settings
// - All ones level routes external pin
// - Crossing in direction sets event flag
// - Interrupt needs event and global enables
// - Settle interval is fixed real time
// - Works in sleep, crossing wakes core
// - Reset disables and restores control
// - Bit six reads zero, ignores writes
`timescale 1ns/1ps
`default_nettype none
module voltage_trip_detector
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_out,
    input  wire logic        ref_ready_in,
    output logic             detector_enable,
    output logic      [3:0]  tap_select,
    output logic             external_trip_input_sel,
    output logic             irq,
    output logic             wake
);
    // ********************
    // Declarations
    // ********************
    vtd_sync_if sync_bus ();                   // Synchronised analog status
    logic [7:0]  ctrl_ff;                      // Writable control bits
    logic        stable_ff;                    // Reference stable flag
    logic        event_ff;                     // Detect event flag
    logic        irq_en_ff;                    // Detect interrupt enable
    logic        prio_ff;                      // Priority bit, stored only
    logic        gie_ff;                       // Global interrupt enable
    logic        sleep_ff;                     // Core sleeping
    logic [15:0] settle_ff;                    // Settle time counter
    vtd_pkg::det_state_t state_ff;             // Detector state
    vtd_pkg::det_state_t nxt_state;            // Next detector state
    logic        cmp_prev_ff;                  // Last comparator sample
    logic        wr_en;                        // APB write strobe
    logic        rd_en;                        // APB read strobe
    logic        crossing;                     // Crossing in chosen direction
    logic        en_now;                       // Current enable bit
    // ********************
    // Helpers
    // ********************
    // Match a register offset on the word address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction : hit
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign en_now = ctrl_ff[vtd_pkg::ENABLE_BIT];
    // ********************
    // Synchroniser
    // ********************
    vtd_sync vtd_sync_inst
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .cmp_async (cmp_out),
        .ref_async (ref_ready_in),
        .sync      (sync_bus.src)
    );
    // ********************
    // Control register
    // ********************
    // Stable flag and bit six are never stored from writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= vtd_pkg::CTRL_RESET;
        end
        else if (wr_en && hit(paddr, vtd_pkg::CTRL_OFFSET))
        begin
            ctrl_ff <= pwdata[7:0] & 8'h9F;
        end
    end
    // ********************
    // Enable registers
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_en_ff <= 1'b0;
            prio_ff   <= 1'b0;
            gie_ff    <= 1'b0;
        end
        else if (wr_en && hit(paddr, vtd_pkg::IRQEN_OFFSET))
        begin
            irq_en_ff <= pwdata[vtd_pkg::EVENT_BIT];
            prio_ff   <= pwdata[vtd_pkg::PRIO_POS];
        end
        else if (wr_en && hit(paddr, vtd_pkg::CORE_OFFSET))
        begin
            gie_ff <= pwdata[vtd_pkg::GIE_BIT];
        end
    end
    // ********************
    // Sleep state
    // ********************
    // Software enters sleep; an event wakes it regardless of enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_ff <= 1'b0;
        end
        else if (event_ff)
        begin
            sleep_ff <= 1'b0;
        end
        else if (wr_en && hit(paddr, vtd_pkg::CORE_OFFSET))
        begin
            sleep_ff <= pwdata[vtd_pkg::SLEEP_BIT];
        end
    end
    // ********************
    // Detector state machine
    // ********************
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            vtd_pkg::ST_OFF:
            begin
                if (en_now)
                begin
                    nxt_state = vtd_pkg::ST_SETTLE;
                end
            end
            vtd_pkg::ST_SETTLE:
            begin
                if (!en_now)
                begin
                    nxt_state = vtd_pkg::ST_OFF;
                end
                else if (settle_ff == 16'h0000 && sync_bus.ref_ready)
                begin
                    nxt_state = vtd_pkg::ST_ARMED;
                end
            end
            vtd_pkg::ST_ARMED:
            begin
                if (!en_now)
                begin
                    nxt_state = vtd_pkg::ST_OFF;
                end
            end
            default:
            begin
                nxt_state = vtd_pkg::ST_OFF;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= vtd_pkg::ST_OFF;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end
    // ********************
    // Settle counter
    // ********************
    // Loaded on every enable so each enable waits the full interval
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle_ff <= 16'h0000;
        end
        else if (state_ff == vtd_pkg::ST_OFF)
        begin
            settle_ff <= 16'(vtd_pkg::SETTLE_CYCLES);
        end
        else if (settle_ff != 16'h0000)
        begin
            settle_ff <= settle_ff - 16'h0001;
        end
    end
    // ********************
    // Stable flag
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stable_ff <= 1'b0;
        end
        else
        begin
            stable_ff <= (nxt_state == vtd_pkg::ST_ARMED);
        end
    end
    // ********************
    // Crossing detection
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_prev_ff <= 1'b0;
        end
        else
        begin
            cmp_prev_ff <= sync_bus.cmp_hi;
        end
    end
    // direction chooses level sense
    // Level sense, not edge: a voltage already past trip still raises the flag
    assign crossing = ctrl_ff[vtd_pkg::DIR_BIT] ? sync_bus.cmp_hi : !sync_bus.cmp_hi;
    // ********************
    // Event flag
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_ff <= 1'b0;
        end
        else if (stable_ff && en_now && crossing)
        begin
            event_ff <= 1'b1;
        end
        // Write one to clear; set above wins
        else if (wr_en && hit(paddr, vtd_pkg::FLAG_OFFSET) && pwdata[vtd_pkg::EVENT_BIT])
        begin
            event_ff <= 1'b0;
        end
    end
    // ********************
    // Analog side outputs
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            detector_enable         <= 1'b0;
            tap_select              <= 4'h0;
            external_trip_input_sel <= 1'b0;
        end
        else
        begin
            detector_enable <= en_now;
            tap_select <= ctrl_ff[vtd_pkg::LEVEL_LSB +: 4];
            external_trip_input_sel <= (ctrl_ff[vtd_pkg::LEVEL_LSB +: 4] == vtd_pkg::LEVEL_EXT);
        end
    end
    // ********************
    // Interrupt and wake
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            irq  <= event_ff && irq_en_ff && gie_ff;
            wake <= event_ff && sleep_ff;
        end
    end
    // ********************
    // APB slave
    // ********************
    // Zero wait states; unmapped reads give zero with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                if (hit(paddr, vtd_pkg::CTRL_OFFSET))
                begin
                    prdata <= {24'h000000, ctrl_ff[7], 1'b0, stable_ff, ctrl_ff[4:0]};
                end
                else if (hit(paddr, vtd_pkg::FLAG_OFFSET))
                begin
                    prdata <= {29'h00000000, event_ff, 2'h0};
                end
                else if (hit(paddr, vtd_pkg::IRQEN_OFFSET))
                begin
                    prdata <= {23'h000000, prio_ff, 5'h00, irq_en_ff, 2'h0};
                end
                else if (hit(paddr, vtd_pkg::CORE_OFFSET))
                begin
                    prdata <= {24'h000000, gie_ff, 6'h00, sleep_ff};
                end
                else
                begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
    // Reads use data fetched in setup; rd_en kept for clarity of strobes
    logic unused_rd;
    assign unused_rd = rd_en | cmp_prev_ff;
endmodule : voltage_trip_detector
`default_nettype wire

// ### tb/voltage_trip_detector_checker.sv
// Checker: port-level assertions on the voltage trip detector
`timescale 1ns/1ps
`default_nettype none
module voltage_trip_detector_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        detector_enable,
    input wire logic [3:0]  tap_select,
    input wire logic        external_trip_input_sel,
    input wire logic        irq,
    input wire logic        wake
);
    // ****************
    // Helper logic
    // ****************
    localparam int ARM_MIN = 32'h3E6; // Shortest enabled run before any event
    logic        wr_ctrl;   // Control write at its access edge
    logic        rd_ctrl;   // Control read data on the bus
    logic [10:0] en_cnt_ff; // Enabled cycles in a row, saturating
    logic        armed_ff;  // Some enable run was long enough
    assign wr_ctrl = psel && penable && pwrite && paddr == vtd_pkg::CTRL_OFFSET;
    assign rd_ctrl = pready && !pwrite && paddr == vtd_pkg::CTRL_OFFSET;
    // Run length of the enable; saturates so it never wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_cnt_ff <= 11'h000;
        else if (!detector_enable)
            en_cnt_ff <= 11'h000;
        else if (en_cnt_ff != 11'h7FF)
            en_cnt_ff <= en_cnt_ff + 11'h001;
    end
    // Sticky, since a set flag outlives the enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_ff <= 1'b0;
        else if (en_cnt_ff >= ARM_MIN)
            armed_ff <= 1'b1;
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_RESET_OFF: assert property ($past(presetn) == 1'b0 |-> !detector_enable && !irq && !wake)
        else $error("outputs active after reset");
    AST_EN_OFF: assert property (wr_ctrl && !pwdata[4] |-> ##[1:2] !detector_enable)
        else $error("detector stays on after disable");
    AST_EN_CAUSE: assert property ($changed(detector_enable) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("enable moved without a write");
    AST_TAP_CAUSE: assert property ($changed(tap_select) && $past(presetn, 2) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("tap moved without a write");
    AST_EXT_SEL: assert property (external_trip_input_sel == (tap_select == vtd_pkg::LEVEL_EXT))
        else $error("external pin select wrong");
    AST_BIT6: assert property (rd_ctrl |-> prdata[6] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("unimplemented bits read nonzero");
    AST_STABLE_LOW: assert property (rd_ctrl && en_cnt_ff != 11'h000 && en_cnt_ff < ARM_MIN |-> !prdata[5])
        else $error("stable flag early");
    AST_EVENT_SETTLE: assert property (irq || wake |-> armed_ff)
        else $error("event before settling");
endmodule : voltage_trip_detector_checker
bind voltage_trip_detector voltage_trip_detector_checker voltage_trip_detector_checker_inst
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .detector_enable, .tap_select, .external_trip_input_sel, .irq, .wake
);
`default_nettype wire

// ### tb/voltage_trip_detector_test.sv
// Testbench: registers, settling and events of the voltage trip detector
`timescale 1ns/1ps
`default_nettype none
module voltage_trip_detector_test;
    logic        pclk = 1'b0;           // 50 MHz clock
    logic        presetn = 1'b0;        // Held low at start
    logic        psel = 1'b0;           // Bus select
    logic        penable = 1'b0;        // Access phase
    logic        pwrite = 1'b0;         // Direction
    logic [7:0]  paddr = 8'h00;         // Byte address
    logic [31:0] pwdata = 32'h0;        // Write word
    logic [31:0] prdata;                // Read word
    logic        pready;                // Slave answer
    logic        pslverr;               // Unmapped access
    logic        cmp_out = 1'b0;        // 1 = at or above trip
    logic        ref_ready_in = 1'b1;   // Reference ready
    logic        detector_enable;       // Detector power
    logic [3:0]  tap_select;            // Divider tap
    logic        external_trip_input_sel; // Pin routed
    logic        irq;                   // Core interrupt
    logic        wake;                  // Sleep wake
    logic [31:0] rd;                    // Last read word
    logic        rd_err;                // Last slave error
    int          error_cnt = 0;         // Mismatches
    int          cmp_count = 0;         // Comparisons
    voltage_trip_detector voltage_trip_detector_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cmp_out, .ref_ready_in, .detector_enable, .tap_select,
        .external_trip_input_sel, .irq, .wake
    );
    always #10 pclk = ~pclk;
    // ****************
    // Tasks
    // ****************
    function automatic logic [31:0] b1(input logic x);
        return {31'h0, x};
    endfunction : b1
    // Expected control word; bit 6 always reads zero
    function automatic logic [31:0] ctrl_exp(input logic d, input logic e,
                                             input logic s, input logic [3:0] l);
        return {24'h0, d, 1'b0, s, e, l};
    endfunction : ctrl_exp
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // One bus transfer; idle edge first so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        // Zero wait: answer on the first access edge
        check("pready", 32'h1, b1(n == 1));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, exp, rd);
    endtask : rdchk
    // Setup order: off, level, direction, on; then settle under random crossings
    task automatic arm(input logic d, input logic [3:0] l);
        apb(1'b1, vtd_pkg::CTRL_OFFSET, ctrl_exp(1'b0, 1'b0, 1'b0, l));
        apb(1'b1, vtd_pkg::CTRL_OFFSET, ctrl_exp(d, 1'b0, 1'b0, l));
        apb(1'b1, vtd_pkg::CTRL_OFFSET, ctrl_exp(d, 1'b1, 1'b0, l));
        rdchk("unsettled", vtd_pkg::CTRL_OFFSET, ctrl_exp(d, 1'b1, 1'b0, l));
        repeat (985)
        begin
            @(posedge pclk);
            cmp_out <= 1'($urandom);
        end
        // Park on the non-tripping side one edge later, never twice in a step
        @(posedge pclk);
        cmp_out <= ~d;
        repeat (29) @(posedge pclk);
        rdchk("settled", vtd_pkg::CTRL_OFFSET, ctrl_exp(d, 1'b1, ref_ready_in, l));
        rdchk("no early event", vtd_pkg::FLAG_OFFSET, 32'h0);
        // Stale flag cleared before the caller's next interrupt enable write
        apb(1'b1, vtd_pkg::FLAG_OFFSET, 32'h4);
    endtask : arm
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // ****************
    // Scenarios
    // ****************
    initial
    begin
        int n;
        void'($urandom(32'hB64D));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl reset", vtd_pkg::CTRL_OFFSET, 32'h5);
        rdchk("flag reset", vtd_pkg::FLAG_OFFSET, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 32'h1, b1(rd_err));
        check("unmapped data", 32'h0, rd);
        apb(1'b1, vtd_pkg::CTRL_OFFSET, 32'hFFFF_FFEA);
        rdchk("ro bits", vtd_pkg::CTRL_OFFSET, ctrl_exp(1'b1, 1'b0, 1'b0, 4'hA));
        for (int i = 0; i < 16; i++)
        begin
            n = 1'($urandom);
            apb(1'b1, vtd_pkg::CTRL_OFFSET, ctrl_exp(n[0], 1'b0, 1'b0, i[3:0]));
            rdchk("level", vtd_pkg::CTRL_OFFSET, ctrl_exp(n[0], 1'b0, 1'b0, i[3:0]));
            check("tap", {28'h0, i[3:0]}, {28'h0, tap_select});
            check("ext sel", b1(i == 15), b1(external_trip_input_sel));
        end
        $display("done: registers");
        ref_ready_in <= 1'b0;
        arm(1'b1, 4'h7);
        ref_ready_in <= 1'b1;
        repeat (5) @(posedge pclk);
        rdchk("stable", vtd_pkg::CTRL_OFFSET, ctrl_exp(1'b1, 1'b1, 1'b1, 4'h7));
        cmp_out <= 1'b1;
        // Two sync stages and the flag edge before the setup edge reads it
        repeat (4) @(posedge pclk);
        rdchk("rise event", vtd_pkg::FLAG_OFFSET, 32'h4);
        apb(1'b1, vtd_pkg::IRQEN_OFFSET, 32'h4);
        repeat (3) @(posedge pclk);
        check("irq no gie", 32'h0, b1(irq));
        apb(1'b1, vtd_pkg::CORE_OFFSET, 32'h80);
        repeat (3) @(posedge pclk);
        check("irq on", 32'h1, b1(irq));
        apb(1'b1, vtd_pkg::FLAG_OFFSET, 32'h4);
        rdchk("set wins", vtd_pkg::FLAG_OFFSET, 32'h4);
        cmp_out <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, vtd_pkg::FLAG_OFFSET, 32'h4);
        rdchk("flag cleared", vtd_pkg::FLAG_OFFSET, 32'h0);
        repeat (3) @(posedge pclk);
        check("irq off", 32'h0, b1(irq));
        $display("done: rising event");
        arm(1'b0, 4'hF);
        check("ext routed", 32'h1, b1(external_trip_input_sel));
        apb(1'b1, vtd_pkg::CORE_OFFSET, 32'h81);
        cmp_out <= 1'b0;
        n = 0;
        while (wake !== 1'b1 && n < 10)
        begin
            @(posedge pclk);
            n++;
        end
        check("wake", 32'h1, b1(wake));
        rdchk("fall event", vtd_pkg::FLAG_OFFSET, 32'h4);
        $display("done: sleep event");
        apb(1'b1, vtd_pkg::CTRL_OFFSET, ctrl_exp(1'b0, 1'b0, 1'b0, 4'hF));
        repeat (3) @(posedge pclk);
        check("disabled", 32'h0, b1(detector_enable));
        rdchk("stable off", vtd_pkg::CTRL_OFFSET, ctrl_exp(1'b0, 1'b0, 1'b0, 4'hF));
        apb(1'b1, vtd_pkg::CTRL_OFFSET, 32'h93);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("reset off", 32'h0, b1(detector_enable));
        rdchk("ctrl again", vtd_pkg::CTRL_OFFSET, 32'h5);
        $display("done: mid reset");
        wrap_up();
    end
    // Hang guard, about twice the expected run
    initial
    begin
        #100_000;
        error_cnt++;
        $display("BAD watchdog expected finish seen hang");
        wrap_up();
    end
endmodule : voltage_trip_detector_test
`default_nettype wire
